// file: macrocell_pkg.sv
// Purpose: Shared constants and types for the programmable macrocell array
// Assumes: 250 MHz system clock, 8-bit programming address, 64-bit programming data
// Notes:   Offsets are word addresses on the programming port
package macrocell_pkg;

    // ------------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------------
    localparam int N_IN          = 12;
    localparam int N_MC          = 10;
    localparam int N_SIG         = N_IN + N_MC;
    localparam int N_COL         = 2 * N_SIG;
    localparam int ROW_W         = N_COL + 1;
    localparam int ROW_EN_BIT    = N_COL;
    localparam int TERMS_PER_MC  = 8;
    localparam int ROWS_PER_MC   = TERMS_PER_MC + 1;
    localparam int OE_ROW_OFS    = TERMS_PER_MC;
    localparam int ROW_ARST      = N_MC * ROWS_PER_MC;
    localparam int ROW_SPRE      = ROW_ARST + 1;
    localparam int N_ROWS        = ROW_SPRE + 1;
    localparam int ROW_IDX_W     = 7;
    localparam int ADDR_W        = 8;
    localparam int DATA_W        = 64;
    localparam int SIG_W         = 64;

    typedef logic [N_ROWS-1:0][ROW_W-1:0] rows_t;

    // ------------------------------------------------------------------
    // Programming port map
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_ROW_BASE = 8'h00;
    localparam logic [7:0] OFF_CFG_BASE = 8'h60;
    localparam logic [7:0] OFF_SIG      = 8'h70;
    localparam logic [7:0] OFF_SECURE   = 8'h71;
    localparam logic [7:0] OFF_PRELOAD  = 8'h72;
    localparam logic [7:0] OFF_STATUS   = 8'h73;
    localparam logic [7:0] OFF_ERASE    = 8'h74;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CFG_BIT_REG      = 0;
    localparam int CFG_BIT_AHI      = 1;
    localparam int SECURE_BIT       = 0;
    localparam int PRELOAD_VAL_LSB  = 0;
    localparam int PRELOAD_MASK_LSB = 16;
    localparam int STATUS_Q_LSB     = 0;
    localparam int STATUS_BUSY_BIT  = 16;
    localparam int STATUS_SEC_BIT   = 17;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [N_MC-1:0]  CFG_REG_RST = 10'h000;
    localparam logic [N_MC-1:0]  CFG_AHI_RST = 10'h000;
    localparam logic [SIG_W-1:0] SIG_RST     = 64'h0000000000000000;
    localparam logic [N_MC-1:0]  MC_Q_RST    = 10'h000;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int POR_MIN_NS    = 600;
    localparam int POR_MAX_NS    = 1000;
    localparam int POR_CYCLES    = (POR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POR_CNT_W     = 8;

endpackage : macrocell_pkg

// file: term_array_mem.sv
// Purpose: Storage of the product-term rows of the macrocell array
// Assumes: One row written per cycle; erase clears every row at once
// Notes:   All rows come out of registers so the array can be evaluated in parallel
`timescale 1ns/1ps
module term_array_mem
    import macrocell_pkg::*;
(
    input  wire logic                 i_clock,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_wr,
    input  wire logic [ROW_IDX_W-1:0] i_row,
    input  wire logic [ROW_W-1:0]     i_wdata,
    input  wire logic                 i_erase,
    output rows_t                     o_rows
);

    typedef struct packed {
        rows_t rows;
    } mem_s;

    mem_s st_r;
    mem_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (i_erase) begin
            st_nxt.rows = '0;
        end else if (i_wr) begin
            st_nxt.rows[i_row] = i_wdata;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_rows = st_r.rows;

endmodule : term_array_mem

// file: macrocell_array.sv
// Purpose: Sum-of-products logic array with ten configurable I/O macrocells
// Assumes: i_pin_clock and all pins are asynchronous to i_clock
// Notes:   Pin outputs are registered on i_clock, adding one system cycle
//
// Overview of operation
// - Power-up clears all macrocell registers low
// - Registered pin level follows programmed output polarity
// - Test preload forces chosen register bits
// - 64-bit signature always readable
// - Security fuse blocks verify and preload; only row reads are blocked, config bits stay readable
// - Undriven pins keep last driven level
// - Twelve inputs, ten macrocells, feedback into array
// - Four output forms: reg/comb, high/low
// - Reset term clears registers without clock
// - Preset term sets registers on clock edge
// - Own term enables each output driver
// - Unused terms disabled and never active
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module macrocell_array
    import macrocell_pkg::*;
(
    input  wire logic              i_clock,
    input  wire logic              i_rst_n,
    input  wire logic              i_pin_clock,
    input  wire logic [N_IN-1:0]   i_in_pin,
    input  wire logic [N_IN-1:0]   i_in_float,
    input  wire logic [N_MC-1:0]   i_io_pin,
    input  wire logic [N_MC-1:0]   i_io_float,
    output logic      [N_MC-1:0]   o_io_out,
    output logic      [N_MC-1:0]   o_io_oe,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [DATA_W-1:0] o_rdata,
    output logic                   o_por_busy
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [N_IN-1:0]      in_s1;
        logic [N_IN-1:0]      in_s2;
        logic [N_IN-1:0]      inf_s1;
        logic [N_IN-1:0]      inf_s2;
        logic [N_IN-1:0]      in_keep;
        logic [N_MC-1:0]      io_s1;
        logic [N_MC-1:0]      io_s2;
        logic [N_MC-1:0]      iof_s1;
        logic [N_MC-1:0]      iof_s2;
        logic [N_MC-1:0]      io_keep;
        logic                 ck_s1;
        logic                 ck_s2;
        logic                 ck_prev;
        logic [N_MC-1:0]      mc_q;
        logic [N_MC-1:0]      cfg_reg;
        logic [N_MC-1:0]      cfg_ahi;
        logic [SIG_W-1:0]     sig;
        logic                 secured;
        logic [POR_CNT_W-1:0] por_cnt;
        logic                 por_busy;
        logic [N_MC-1:0]      io_out;
        logic [N_MC-1:0]      io_oe;
        logic [DATA_W-1:0]    rdata;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    rows_t                rows;
    logic                 row_wr;
    logic                 erase;
    logic [ROW_IDX_W-1:0] row_idx;
    logic                 addr_is_row;
    logic                 addr_is_cfg;
    logic [3:0]           cfg_idx;
    logic [N_SIG-1:0]     sig_lvl;
    logic [N_COL-1:0]     cols;
    logic [N_ROWS-1:0]    term;
    logic [N_MC-1:0]      sum;
    logic [N_MC-1:0]      fb;
    logic                 ck_rise;
    logic [N_MC-1:0]      pl_mask;
    logic [N_MC-1:0]      pl_val;

    // ------------------------------------------------------------------
    // Product-term storage
    // ------------------------------------------------------------------
    term_array_mem u_rows (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_wr    (row_wr),
        .i_row   (row_idx),
        .i_wdata (i_wdata[ROW_W-1:0]),
        .i_erase (erase),
        .o_rows  (rows)
    );

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    always_comb begin
        row_idx     = i_addr[ROW_IDX_W-1:0];
        addr_is_row = (i_addr >= OFF_ROW_BASE) && (i_addr < OFF_ROW_BASE + 8'(N_ROWS));
        addr_is_cfg = (i_addr >= OFF_CFG_BASE) && (i_addr < OFF_CFG_BASE + 8'(N_MC));
        cfg_idx     = 4'(i_addr - OFF_CFG_BASE);
        row_wr      = i_wr && addr_is_row;
        erase       = i_wr && (i_addr == OFF_ERASE);
        pl_val      = i_wdata[PRELOAD_VAL_LSB +: N_MC];
        pl_mask     = i_wdata[PRELOAD_MASK_LSB +: N_MC];
    end

    // ------------------------------------------------------------------
    // Array evaluation
    // ------------------------------------------------------------------
    always_comb begin
        // Combinatorial cells feed back from the pin, registered ones from Q
        for (int c = 0; c < N_MC; c++) begin
            fb[c] = st_r.cfg_reg[c] ? st_r.mc_q[c] : st_r.io_keep[c];
        end
        sig_lvl = {fb, st_r.in_keep};
        for (int s = 0; s < N_SIG; s++) begin
            cols[2*s]     = sig_lvl[s];
            cols[2*s + 1] = ~sig_lvl[s];
        end
        // Disabled rows never fire, so they never toggle
        for (int r = 0; r < N_ROWS; r++) begin
            term[r] = rows[r][ROW_EN_BIT] & (&(~rows[r][N_COL-1:0] | cols));
        end
        for (int c = 0; c < N_MC; c++) begin
            sum[c] = |term[c*ROWS_PER_MC +: TERMS_PER_MC];
        end
        ck_rise = st_r.ck_s2 & ~st_r.ck_prev;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;

        // Pin synchronisers
        st_nxt.in_s1   = i_in_pin;
        st_nxt.in_s2   = st_r.in_s1;
        st_nxt.inf_s1  = i_in_float;
        st_nxt.inf_s2  = st_r.inf_s1;
        st_nxt.io_s1   = i_io_pin;
        st_nxt.io_s2   = st_r.io_s1;
        st_nxt.iof_s1  = i_io_float;
        st_nxt.iof_s2  = st_r.iof_s1;
        st_nxt.ck_s1   = i_pin_clock;
        st_nxt.ck_s2   = st_r.ck_s1;
        st_nxt.ck_prev = st_r.ck_s2;

        // Keepers hold the last driven level of a floating pin
        for (int i = 0; i < N_IN; i++) begin
            st_nxt.in_keep[i] = st_r.inf_s2[i] ? st_r.in_keep[i] : st_r.in_s2[i];
        end
        for (int c = 0; c < N_MC; c++) begin
            if (st_r.io_oe[c]) begin
                st_nxt.io_keep[c] = st_r.io_out[c];
            end else if (!st_r.iof_s2[c]) begin
                st_nxt.io_keep[c] = st_r.io_s2[c];
            end
        end

        // Power-up interval
        if (st_r.por_busy) begin
            if (st_r.por_cnt == POR_CNT_W'(POR_CYCLES - 1)) begin
                st_nxt.por_busy = 1'b0;
            end else begin
                st_nxt.por_cnt = st_r.por_cnt + 1'b1;
            end
        end

        // Macrocell registers, highest priority first
        if (st_r.por_busy) begin
            // Pin clock edges are ignored until the interval ends
            st_nxt.mc_q = MC_Q_RST;
        end else if (term[ROW_ARST]) begin
            st_nxt.mc_q = MC_Q_RST;
        end else if (i_wr && (i_addr == OFF_PRELOAD) && !st_r.secured) begin
            st_nxt.mc_q = (st_r.mc_q & ~pl_mask) | (pl_val & pl_mask);
        end else if (ck_rise) begin
            if (term[ROW_SPRE]) begin
                st_nxt.mc_q = '1;
            end else begin
                st_nxt.mc_q = sum;
            end
        end

        // Output forms and drivers
        for (int c = 0; c < N_MC; c++) begin
            st_nxt.io_out[c] = (st_r.cfg_reg[c] ? st_nxt.mc_q[c] : sum[c]) ^ ~st_r.cfg_ahi[c];
            st_nxt.io_oe[c]  = term[c*ROWS_PER_MC + OE_ROW_OFS];
        end

        // Programming writes
        if (i_wr) begin
            if (addr_is_cfg) begin
                st_nxt.cfg_reg[cfg_idx] = i_wdata[CFG_BIT_REG];
                st_nxt.cfg_ahi[cfg_idx] = i_wdata[CFG_BIT_AHI];
            end else if (i_addr == OFF_SIG) begin
                st_nxt.sig = i_wdata[SIG_W-1:0];
            end else if (i_addr == OFF_SECURE) begin
                // Takes effect on the very next access
                st_nxt.secured = st_r.secured | i_wdata[SECURE_BIT];
            end else if (erase) begin
                st_nxt.cfg_reg = CFG_REG_RST;
                st_nxt.cfg_ahi = CFG_AHI_RST;
                st_nxt.sig     = SIG_RST;
                st_nxt.secured = 1'b0;
            end
        end

        // Programming reads; data stand for one cycle only
        st_nxt.rdata = '0;
        if (i_rd) begin
            if (addr_is_row) begin
                if (!st_r.secured) begin
                    st_nxt.rdata = DATA_W'(rows[row_idx]);
                end
            end else if (addr_is_cfg) begin
                st_nxt.rdata[CFG_BIT_REG] = st_r.cfg_reg[cfg_idx];
                st_nxt.rdata[CFG_BIT_AHI] = st_r.cfg_ahi[cfg_idx];
            end else if (i_addr == OFF_SIG) begin
                st_nxt.rdata = DATA_W'(st_r.sig);
            end else if (i_addr == OFF_SECURE) begin
                st_nxt.rdata[SECURE_BIT] = st_r.secured;
            end else if (i_addr == OFF_STATUS) begin
                st_nxt.rdata[STATUS_Q_LSB +: N_MC] = st_r.mc_q;
                st_nxt.rdata[STATUS_BUSY_BIT]      = st_r.por_busy;
                st_nxt.rdata[STATUS_SEC_BIT]       = st_r.secured;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            st_r          <= '0;
            st_r.cfg_reg  <= CFG_REG_RST;
            st_r.cfg_ahi  <= CFG_AHI_RST;
            st_r.sig      <= SIG_RST;
            st_r.mc_q     <= MC_Q_RST;
            st_r.por_busy <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_io_out   = st_r.io_out;
    assign o_io_oe    = st_r.io_oe;
    assign o_rdata    = st_r.rdata;
    assign o_por_busy = st_r.por_busy;

endmodule : macrocell_array

// file: array_monitor.sv
// Purpose: Port checker for the macrocell array
// Assumes: Bound to every macrocell_array instance
// Notes:   Mirrors signature and security state from port traffic
`timescale 1ns/1ps
module array_monitor
    import macrocell_pkg::*;
(
    input  wire logic              i_clock,
    input  wire logic              i_rst_n,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    input  wire logic [DATA_W-1:0] o_rdata,
    input  wire logic [N_MC-1:0]   o_io_out,
    input  wire logic [N_MC-1:0]   o_io_oe,
    input  wire logic              o_por_busy
);
    // ------------------------------------------------------------------
    // Shadow state
    // ------------------------------------------------------------------
    logic [SIG_W-1:0] sig_r;
    logic             sec_r;
    logic [7:0]       up_r;
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || (i_wr && i_addr == OFF_ERASE)) begin
            sig_r <= SIG_RST;
            sec_r <= 1'b0;
        end else if (i_wr && i_addr == OFF_SIG) begin
            sig_r <= i_wdata;
        end else if (i_wr && i_addr == OFF_SECURE && i_wdata[SECURE_BIT]) begin
            sec_r <= 1'b1;
        end
        up_r <= !i_rst_n ? 8'h00 : (up_r == 8'hFF) ? up_r : up_r + 8'h01;
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_reset_quiet: assert property ($rose(i_rst_n) |->
        o_io_out == '0 && o_io_oe == '0 && o_rdata == '0 && o_por_busy) else $error("outputs not idle after reset");
    a_busy_early: assert property (up_r < POR_CYCLES |-> o_por_busy) else $error("busy ended early");
    a_busy_late: assert property (up_r > POR_CYCLES |-> !o_por_busy) else $error("busy stayed too long");
    a_status_busy_q: assert property (i_rd && i_addr == OFF_STATUS && o_por_busy
        |=> o_rdata[N_MC-1:0] == '0) else $error("register not clear while busy");
    a_rdata_idle: assert property (!i_rd |=> o_rdata == '0) else $error("read data outside read slot");
    a_sig_read: assert property (i_rd && i_addr == OFF_SIG |=> o_rdata == sig_r) else $error("signature wrong");
    a_row_locked: assert property (i_rd && i_addr < 8'h5C && sec_r |=> o_rdata == '0)
        else $error("row readable while secured");
    a_status_sec: assert property (i_rd && i_addr == OFF_STATUS |=> o_rdata[STATUS_SEC_BIT] == sec_r)
        else $error("secured flag wrong");
    a_unmapped_zero: assert property (i_rd && (i_addr > OFF_ERASE || (i_addr > 8'h5B && i_addr < OFF_CFG_BASE))
        |=> o_rdata == '0) else $error("unmapped read not zero");
    cover property (i_rd && i_addr == OFF_SIG && sec_r);
    cover property (i_wr && i_addr == OFF_PRELOAD);
    cover property ($fell(o_por_busy));
endmodule : array_monitor

bind macrocell_array array_monitor i_array_monitor (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_io_out(o_io_out), .o_io_oe(o_io_oe),
    .o_por_busy(o_por_busy));

// file: system_model.sv
// Purpose: System logic driving the array pins and pin clock
// Assumes: Released pins show a changing pattern
// Notes:   Pin clock edges only on request
`timescale 1ns/1ps
module system_model
    import macrocell_pkg::*;
(
    input  wire logic            i_clock,
    input  wire logic            i_clk_req,
    input  wire logic [N_IN-1:0] i_in_val,
    input  wire logic [N_IN-1:0] i_in_rel,
    input  wire logic [N_MC-1:0] i_io_out,
    input  wire logic [N_MC-1:0] i_io_oe,
    input  wire logic            i_por_busy,
    output logic                 o_pin_clock,
    output logic [N_IN-1:0]      o_in_pin,
    output logic [N_IN-1:0]      o_in_float,
    output logic [N_MC-1:0]      o_io_pin,
    output logic [N_MC-1:0]      o_io_float
);
    // Toggling pattern shown on released pins; pin levels settle after the first edge
    logic [N_IN-1:0] junk = '0;
    initial begin
        o_pin_clock = 1'b0;
        forever begin
            @(posedge i_clock);
            if (i_clk_req) begin
                while (i_por_busy) @(posedge i_clock);
                repeat (3) @(posedge i_clock);
                o_pin_clock <= 1'b1;
                repeat (4) @(posedge i_clock);
                o_pin_clock <= 1'b0;
                repeat (4) @(posedge i_clock);
            end
        end
    end
    always @(posedge i_clock) begin
        junk <= ~junk;
        o_in_pin <= (i_in_val & ~i_in_rel) | (junk & i_in_rel);
        o_in_float <= i_in_rel;
        o_io_pin <= (i_io_out & i_io_oe) | (junk[N_MC-1:0] & ~i_io_oe);
        o_io_float <= ~i_io_oe;
    end
endmodule : system_model

// file: macrocell_array_tb.sv
// Purpose: Self-checking bench for the macrocell array
// Assumes: Register model kept in bench variables
// Notes:   Pin clock comes from the system model
`timescale 1ns/1ps
module macrocell_array_tb import macrocell_pkg::*;;
    logic              clock;
    logic              rst_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, v;
    logic              wr, rd, clk_req, pin_clock, por_busy, m_sec;
    logic [N_IN-1:0]   in_val, in_rel, in_pin, in_float;
    logic [N_MC-1:0]   io_pin, io_float, io_out, io_oe, m_q, m_reg, m_ahi;
    logic [SIG_W-1:0]  m_sig;
    integer            seed = 32'hE920;
    int                n_errors = 0;
    int                check_count = 0;
    macrocell_array i_macrocell_array (.i_clock(clock), .i_rst_n(rst_n), .i_pin_clock(pin_clock),
        .i_in_pin(in_pin), .i_in_float(in_float), .i_io_pin(io_pin), .i_io_float(io_float), .o_io_out(io_out),
        .o_io_oe(io_oe), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_por_busy(por_busy));
    system_model i_system_model (.i_clock(clock), .i_clk_req(clk_req), .i_in_val(in_val), .i_in_rel(in_rel),
        .i_io_out(io_out), .i_io_oe(io_oe), .i_por_busy(por_busy), .o_pin_clock(pin_clock), .o_in_pin(in_pin),
        .o_in_float(in_float), .o_io_pin(io_pin), .o_io_float(io_float));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task test_done;
        if (n_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done
    task chk(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wr_reg(input logic [7:0] a, input logic [63:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask : wr_reg
    task rd_reg(input logic [7:0] a, input logic [63:0] e);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask : rd_reg
    task pulse_clk;
        @(posedge clock);
        clk_req <= 1'b1;
        @(posedge clock);
        clk_req <= 1'b0;
        repeat (20) @(posedge clock);
    endtask : pulse_clk
    function logic [63:0] st(input logic busy);
        st = 64'h0;
        st[N_MC-1:0] = m_q;
        st[STATUS_BUSY_BIT] = busy;
        st[STATUS_SEC_BIT] = m_sec;
    endfunction : st
    function logic [N_MC-1:0] out_exp(input logic [N_MC-1:0] comb);
        out_exp = ((m_reg & m_q) | (~m_reg & comb)) ^ ~m_ahi;
    endfunction : out_exp
    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        test_done();
    end
    initial begin
        {rst_n, addr, wdata, wr, rd, clk_req, in_val, in_rel, m_sec} = '0;
        m_sig = SIG_RST;
        m_q = MC_Q_RST;
        m_reg = CFG_REG_RST;
        m_ahi = CFG_AHI_RST;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        rd_reg(OFF_STATUS, st(1'b1));
        for (int i = 0; i < 200 && por_busy; i++) @(posedge clock);
        chk(por_busy, 1'b0);
        v = {$random(seed), $random(seed)};
        wr_reg(OFF_SIG, v);
        m_sig = v;
        rd_reg(OFF_SIG, m_sig);
        rd_reg(8'h75, 64'h0);
        for (int k = 0; k < 4; k++) begin
            v = {$random(seed), $random(seed)};
            m_reg = v[9:0];
            m_ahi = v[19:10];
            for (int c = 0; c < N_MC; c++) wr_reg(OFF_CFG_BASE + 8'(c), {62'h0, m_ahi[c], m_reg[c]});
            v = {$random(seed), $random(seed)};
            wr_reg(OFF_PRELOAD, v);
            m_q = (m_q & ~v[25:16]) | (v[9:0] & v[25:16]);
            rd_reg(OFF_STATUS, st(1'b0));
            chk(io_out, out_exp(10'h000));
            chk(io_oe, 10'h000);
        end
        wr_reg(OFF_CFG_BASE, 64'h3);
        m_reg[0] = 1'b1;
        m_ahi[0] = 1'b1;
        wr_reg(8'h00, (64'h1 << ROW_EN_BIT) | 64'h1);
        rd_reg(8'h00, (64'h1 << ROW_EN_BIT) | 64'h1);
        in_val <= 12'h001;
        pulse_clk();
        m_q = 10'h001;
        rd_reg(OFF_STATUS, st(1'b0));
        chk(io_out, out_exp(10'h000));
        wr_reg(8'h5B, 64'h1 << ROW_EN_BIT);
        in_val <= 12'h000;
        pulse_clk();
        m_q = 10'h3FF;
        rd_reg(OFF_STATUS, st(1'b0));
        wr_reg(8'h5B, 64'h0);
        wr_reg(8'h5A, (64'h1 << ROW_EN_BIT) | 64'h4);
        in_val <= 12'h002;
        repeat (10) @(posedge clock);
        m_q = 10'h000;
        rd_reg(OFF_STATUS, st(1'b0));
        in_val <= 12'h004;
        wr_reg(OFF_CFG_BASE + 8'h03, 64'h2);
        m_reg[3] = 1'b0;
        m_ahi[3] = 1'b1;
        wr_reg(8'h1B, (64'h1 << ROW_EN_BIT) | 64'h10);
        wr_reg(8'h1A, 64'h1 << ROW_EN_BIT);
        repeat (10) @(posedge clock);
        #1;
        chk(io_out, out_exp(10'h008));
        chk(io_oe, 10'h004);
        in_rel <= 12'h004;
        in_val <= 12'h000;
        repeat (10) @(posedge clock);
        #1;
        chk(io_out, out_exp(10'h008));
        wr_reg(OFF_SECURE, 64'h1);
        m_sec = 1'b1;
        rd_reg(8'h00, 64'h0);
        wr_reg(OFF_PRELOAD, 64'h03FF03FF);
        rd_reg(OFF_STATUS, st(1'b0));
        rd_reg(OFF_SIG, m_sig);
        wr_reg(OFF_ERASE, 64'h0);
        m_sig = SIG_RST;
        m_sec = 1'b0;
        rd_reg(OFF_SIG, m_sig);
        test_done();
    end
endmodule : macrocell_array_tb
